// [verilog/spi_keypad_scanner.sv]
// Serial register interface and 6x5 keypad scanner
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Three-stage input filter: a change counts once stages 2, 3 agree
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] cleanOut
);
  logic [WIDTH-1:0] stage1; // Only read by stage2
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  assign agree = ~(stage2 ^ stage3);

  // Shift chain and agreement filter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      cleanOut <= INIT;
    end else begin
      stage1 <= rawIn;
      stage2 <= stage1;
      stage3 <= stage2;
      cleanOut <= (stage2 & agree) | (cleanOut & ~agree);
    end
  end
endmodule : pin_sync

// ============================================================
// Top of the keypad scanner
module spi_keypad_scanner #(
  parameter int unsigned DEBOUNCE_UNIT =
    keypad_scan_pkg::DEBOUNCE_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial host port
  input wire logic chipSelect_n,
  input wire logic serialClock,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOutOe_n,
  output logic busy,
  output logic busyOe_n,
  // Keypad matrix
  output logic [5:0] columnDriveLines,
  output logic [5:0] columnDriveOe_n,
  input wire logic [4:0] rowSenseLines,
  output logic keyIrq_n
);
  import keypad_scan_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [7:0] rawPins;
  logic [7:0] cleanPins;
  logic csnClean;
  logic sclkClean;
  logic dinClean;
  logic [4:0] rowsClean;

  assign rawPins = {rowSenseLines, serialDataIn, serialClock, chipSelect_n};
  assign csnClean = cleanPins[0];
  assign sclkClean = cleanPins[1];
  assign dinClean = cleanPins[2];
  assign rowsClean = cleanPins[7:3];

  // Reset levels match idle pins: deselected, link clock parked high
  pin_sync #(.WIDTH(8), .INIT(8'h03)) u_pins (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rawIn(rawPins),
    .cleanOut(cleanPins)
  );

  // ==========================================================
  // Serial frame engine
  logic sclkPrev;        // Last filtered clock level
  logic [5:0] bitCount;  // Rising edges seen in this frame
  logic [15:0] rxShift;  // Incoming bits
  logic [15:0] txShift;  // Outgoing read word
  spi_cmd_type cmdWord;  // Command held for the data phase
  logic [2:0] touchCtrl; // Last axis and powerdown bit
  spi_cmd_type cmdNext;
  logic [15:0] rxNext;
  logic [15:0] readWord;
  logic sclkRise;
  logic sclkFall;
  logic cmdDone;
  logic frameDone;
  logic dataReadPulse;
  logic txPhase;

  assign sclkRise = sclkClean & ~sclkPrev & ~csnClean;
  assign sclkFall = ~sclkClean & sclkPrev & ~csnClean;
  assign rxNext = {rxShift[14:0], dinClean};
  assign cmdNext = rxNext;
  assign cmdDone = sclkRise && (bitCount == CMD_BITS - 6'h01);
  assign frameDone = sclkRise && (bitCount == FRAME_BITS - 6'h01);
  assign txPhase = (bitCount >= CMD_BITS) && (bitCount < FRAME_BITS);
  // Reading either keypad data word releases the hold-off
  assign dataReadPulse = cmdDone && !cmdNext.touchStart &&
    cmdNext.readNotWrite && !cmdNext.page &&
    ((cmdNext.addr == KEYPAD_DATA_LOW_OFS) ||
     (cmdNext.addr == KEYPAD_DATA_HIGH_OFS));

  // Bit counter and receive shifter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev <= 1'b1; // Idle level, so no false edge after reset
      bitCount <= 6'h00;
      rxShift <= REG_RESET;
    end else begin
      sclkPrev <= sclkClean;
      if (csnClean) begin
        bitCount <= 6'h00;
      end else if (sclkRise && bitCount < FRAME_BITS) begin
        bitCount <= bitCount + 6'h01;
        rxShift <= rxNext;
      end
    end
  end

  // Command capture and touch command latch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdWord <= '0;
      touchCtrl <= 3'h0;
    end else if (cmdDone) begin
      cmdWord <= cmdNext;
      if (cmdNext.touchStart) begin
        touchCtrl <= {cmdNext.axisSelect, cmdNext.driverPowerdownBit};
      end
    end
  end

  // Transmit: word loaded after the command, bits change on falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift <= REG_RESET;
      serialDataOut <= 1'b0;
    end else if (csnClean) begin
      serialDataOut <= 1'b0;
    end else if (cmdDone) begin
      txShift <= readWord;
    end else if (sclkFall && txPhase) begin
      serialDataOut <= txShift[15];
      txShift <= {txShift[14:0], 1'b0};
    end
  end

  // Output enables follow chip select; busy is held low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serialDataOutOe_n <= 1'b1;
      busyOe_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      serialDataOutOe_n <= csnClean;
      busyOe_n <= csnClean;
      busy <= 1'b0;
    end
  end

  // ==========================================================
  // Register file
  logic [15:0] keypadConfig;
  logic [15:0] keyMaskLow;
  logic [15:0] keyMaskHigh;
  logic [15:0] columnMask;
  logic [15:0] powerDownControl;
  logic [15:0] gpioFunctionSelect;
  logic [15:0] gpioDirection;
  logic [15:0] gpioPullEnable;
  logic [15:0] gpioOutputSetting;
  logic [15:0] pwmControl;
  logic [15:0] keypadDataLow;
  logic [15:0] keypadDataHigh;
  logic ctlWrite;
  logic scanTriggerWrite;
  logic [15:0] dataPageWord;
  logic [15:0] ctlPageWord;

  // Writes land at the last bit; page 0 and touch frames store nothing
  assign ctlWrite = frameDone && !cmdWord.touchStart &&
    !cmdWord.readNotWrite && cmdWord.page;
  assign scanTriggerWrite = ctlWrite &&
    (cmdWord.addr == SCAN_TRIGGER_OFS);

  // Read selection by page and address; others read zero
  assign dataPageWord =
    (cmdNext.addr == KEYPAD_DATA_LOW_OFS) ? keypadDataLow :
    (cmdNext.addr == KEYPAD_DATA_HIGH_OFS) ? keypadDataHigh :
    REG_RESET;
  assign ctlPageWord =
    (cmdNext.addr == KEYPAD_CONFIG_OFS) ? keypadConfig :
    (cmdNext.addr == KEY_MASK_LOW_OFS) ? keyMaskLow :
    (cmdNext.addr == KEY_MASK_HIGH_OFS) ? keyMaskHigh :
    (cmdNext.addr == COLUMN_MASK_OFS) ? columnMask :
    (cmdNext.addr == POWER_DOWN_CONTROL_OFS) ? powerDownControl :
    (cmdNext.addr == GPIO_FUNCTION_SELECT_OFS) ? gpioFunctionSelect :
    (cmdNext.addr == GPIO_DIRECTION_OFS) ? gpioDirection :
    (cmdNext.addr == GPIO_PULL_ENABLE_OFS) ? gpioPullEnable :
    (cmdNext.addr == GPIO_OUTPUT_SETTING_OFS) ? gpioOutputSetting :
    (cmdNext.addr == PWM_CONTROL_OFS) ? pwmControl :
    REG_RESET;
  assign readWord = cmdNext.touchStart ? REG_RESET :
    (cmdNext.page ? ctlPageWord : dataPageWord);

  // Control register writes, masked to their defined bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      keypadConfig <= REG_RESET;
      keyMaskLow <= REG_RESET;
      keyMaskHigh <= REG_RESET;
      columnMask <= REG_RESET;
      powerDownControl <= REG_RESET;
      gpioFunctionSelect <= REG_RESET;
      gpioDirection <= REG_RESET;
      gpioPullEnable <= REG_RESET;
      gpioOutputSetting <= REG_RESET;
      pwmControl <= REG_RESET;
    end else if (ctlWrite) begin
      case (cmdWord.addr)
        KEYPAD_CONFIG_OFS: keypadConfig <= rxNext & KEYPAD_CONFIG_WMASK;
        KEY_MASK_LOW_OFS: keyMaskLow <= rxNext & KEY_MASK_WMASK;
        KEY_MASK_HIGH_OFS: keyMaskHigh <= rxNext & KEY_MASK_WMASK;
        COLUMN_MASK_OFS: columnMask <= rxNext & COLUMN_MASK_WMASK;
        POWER_DOWN_CONTROL_OFS: begin
          powerDownControl <= rxNext & POWER_DOWN_WMASK;
        end
        GPIO_FUNCTION_SELECT_OFS: begin
          gpioFunctionSelect <= rxNext & GPIO_LOW_WMASK;
        end
        GPIO_DIRECTION_OFS: gpioDirection <= rxNext & GPIO_HIGH_WMASK;
        GPIO_PULL_ENABLE_OFS: gpioPullEnable <= rxNext & GPIO_HIGH_WMASK;
        GPIO_OUTPUT_SETTING_OFS: begin
          gpioOutputSetting <= rxNext & GPIO_HIGH_WMASK;
        end
        PWM_CONTROL_OFS: pwmControl <= rxNext & PWM_CONTROL_WMASK;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Rate dividers: debounce unit and column settle enables
  logic [31:0] unitCount;
  logic [15:0] settleCount;
  logic unitTick;
  logic settleTick;

  assign unitTick = (unitCount == DEBOUNCE_UNIT - 1);
  assign settleTick = (settleCount == 16'(COLUMN_SETTLE_CYCLES - 1));

  // Free-running dividers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unitCount <= 32'h0000_0000;
      settleCount <= 16'h0000;
    end else begin
      unitCount <= unitTick ? 32'h0000_0000 : unitCount + 32'h0000_0001;
      settleCount <= settleTick ? 16'h0000 : settleCount + 16'h0001;
    end
  end

  // ==========================================================
  // Keypad scanner
  scan_state_type scanState;
  logic [2:0] column;         // Column under scan
  logic settled;              // Column has passed one settleTick under scan
  logic [3:0] debounceUnits;  // Units elapsed in the debounce wait
  logic debounceError;        // No key left at end of debounce
  logic [4:0] scanBuf [6];    // Row sample per column
  logic keysEnabled;
  logic rowsAny;
  logic [3:0] debounceTarget;
  logic columnMasked;
  logic lastColumn;
  logic [14:0] keysLow;
  logic [14:0] keysHigh;

  assign keysEnabled = ~powerDownControl[KEYPAD_POWERDOWN_BIT];
  assign rowsAny = |rowsClean;
  assign debounceTarget =
    {1'b0, keypadConfig[DEBOUNCE_FIELD_LSB +: 3]} + 4'h1;
  assign columnMasked = columnMask[column];
  assign lastColumn = (column == 3'h5);
  assign keysLow = {scanBuf[2], scanBuf[1], scanBuf[0]} &
    ~keyMaskLow[14:0];
  assign keysHigh = {scanBuf[5], scanBuf[4], scanBuf[3]} &
    ~keyMaskHigh[14:0];

  // Detect, debounce, scan, then hold until the host reads
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scanState <= ST_IDLE;
      column <= 3'h0;
      settled <= 1'b0;
      debounceUnits <= 4'h0;
      debounceError <= 1'b0;
      keyIrq_n <= 1'b1;
      keypadDataLow <= REG_RESET;
      keypadDataHigh <= REG_RESET;
      for (int i = 0; i < 6; i++) begin
        scanBuf[i] <= 5'h00;
      end
    end else begin
      case (scanState)
        ST_IDLE: begin
          column <= 3'h0;
          settled <= 1'b0;
          debounceUnits <= 4'h0;
          if (scanTriggerWrite) begin
            debounceError <= 1'b0;
            scanState <= ST_SCAN;
          end else if (keysEnabled && rowsAny) begin
            keyIrq_n <= 1'b0;
            scanState <= ST_DEBOUNCE;
          end
        end
        ST_DEBOUNCE: begin
          if (unitTick) begin
            debounceUnits <= debounceUnits + 4'h1;
          end
          if (unitTick && debounceUnits + 4'h1 == debounceTarget) begin
            debounceError <= ~rowsAny;
            scanState <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (columnMasked) begin
            scanBuf[column] <= 5'h00;
            settled <= 1'b0;
          end else if (settleTick && !settled) begin
            settled <= 1'b1;
          end else if (settleTick) begin
            scanBuf[column] <= rowsClean;
            settled <= 1'b0;
          end
          if (columnMasked || (settleTick && settled)) begin
            column <= column + 3'h1;
            if (lastColumn) begin
              scanState <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          // Data reloads on every cycle in hold; wait for a keypad data read
          keypadDataLow <= {debounceError, keysLow};
          keypadDataHigh <= {1'b0, keysHigh};
          keyIrq_n <= 1'b1;
          if (dataReadPulse) begin
            scanState <= ST_IDLE;
          end
        end
        default: scanState <= ST_IDLE;
      endcase
    end
  end

  // Column pins: all high when armed, one high while scanning
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      columnDriveLines <= 6'h00;
      columnDriveOe_n <= 6'h3F;
    end else if (scanState == ST_SCAN) begin
      columnDriveLines <= 6'h01 << column;
      columnDriveOe_n <= columnMasked ? 6'h3F : ~(6'h01 << column);
    end else if (keysEnabled &&
                 (scanState == ST_IDLE || scanState == ST_DEBOUNCE)) begin
      columnDriveLines <= 6'h3F;
      columnDriveOe_n <= 6'h00;
    end else begin
      columnDriveLines <= 6'h00;
      columnDriveOe_n <= 6'h3F;
    end
  end

endmodule : spi_keypad_scanner

`default_nettype wire

// [include/keypad_scan_pkg.sv]
// Constants, types and register map of the serial keypad scanner
package keypad_scan_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Least settle time of a driven column before its rows are sampled
  localparam int unsigned COLUMN_SETTLE_NS = 10000;
  localparam int unsigned COLUMN_SETTLE_CYCLES =
    (COLUMN_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // One step of the debounce interval field
  localparam int unsigned DEBOUNCE_UNIT_US = 1000;
  localparam int unsigned DEBOUNCE_UNIT_CYCLES =
    (DEBOUNCE_UNIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // Serial frame
  localparam logic [5:0] CMD_BITS = 6'h10;
  localparam logic [5:0] FRAME_BITS = 6'h20;

  // Command word: touch byte then register byte, MSB first
  typedef struct packed {
    logic touchStart;
    logic [1:0] axisSelect;
    logic driverPowerdownBit;
    logic [3:0] spare;
    logic readNotWrite;
    logic page;
    logic [5:0] addr;
  } spi_cmd_type;

  // ==========================================================
  // Register offsets (page 0 data, page 1 control)
  localparam logic [5:0] KEYPAD_DATA_LOW_OFS = 6'h00;
  localparam logic [5:0] KEYPAD_DATA_HIGH_OFS = 6'h01;
  localparam logic [5:0] GPIO_PIN_LEVEL_OFS = 6'h10;
  localparam logic [5:0] KEYPAD_CONFIG_OFS = 6'h00;
  localparam logic [5:0] KEY_MASK_LOW_OFS = 6'h01;
  localparam logic [5:0] KEY_MASK_HIGH_OFS = 6'h02;
  localparam logic [5:0] COLUMN_MASK_OFS = 6'h03;
  localparam logic [5:0] SCAN_TRIGGER_OFS = 6'h04;
  localparam logic [5:0] POWER_DOWN_CONTROL_OFS = 6'h08;
  localparam logic [5:0] GPIO_FUNCTION_SELECT_OFS = 6'h10;
  localparam logic [5:0] GPIO_DIRECTION_OFS = 6'h11;
  localparam logic [5:0] GPIO_PULL_ENABLE_OFS = 6'h12;
  localparam logic [5:0] GPIO_OUTPUT_SETTING_OFS = 6'h13;
  localparam logic [5:0] PWM_CONTROL_OFS = 6'h18;

  // Writable bits of each control register
  localparam logic [15:0] KEYPAD_CONFIG_WMASK = 16'hFF00;
  localparam logic [15:0] KEY_MASK_WMASK = 16'h7FFF;
  localparam logic [15:0] COLUMN_MASK_WMASK = 16'h003F;
  localparam logic [15:0] POWER_DOWN_WMASK = 16'h0003;
  localparam logic [15:0] GPIO_LOW_WMASK = 16'h00FF;
  localparam logic [15:0] GPIO_HIGH_WMASK = 16'hFF00;
  localparam logic [15:0] PWM_CONTROL_WMASK = 16'h9F47;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Field positions
  localparam int unsigned DEBOUNCE_FIELD_LSB = 11;
  localparam int unsigned KEYPAD_POWERDOWN_BIT = 1;
  localparam int unsigned ERROR_FLAG_BIT = 15;

  // Scanner states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DEBOUNCE = 4'b0010,
    ST_SCAN = 4'b0100,
    ST_HOLD = 4'b1000
  } scan_state_type;

endpackage : keypad_scan_pkg

// [testbench/spi_host_model.sv]
// Host-side serial master model that drives register frames
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Serial bus master
module spi_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial lines towards the scanner
  output logic chipSelect_n,
  output logic serialClock,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  // Half period of 40 ns keeps the link clock at 12.5 MHz / 1 = 80 ns
  localparam int HALF = 8;

  // Idle: deselected, link clock parked high
  initial begin
    chipSelect_n = 1'b1;
    serialClock = 1'b1;
    serialDataIn = 1'b0;
  end

  // One frame, MSB first; fewer than 32 bits makes a short frame
  task automatic frame(input logic [15:0] cmd, input logic [15:0] wdata,
                       input int nbits, output logic [15:0] rdata);
    logic [31:0] word;
    word = {cmd, wdata};
    rdata = 16'h0000;
    @(posedge sys_clk);
    chipSelect_n <= 1'b0;
    repeat (60) @(posedge sys_clk); // Select to first clock fall
    for (int i = 0; i < nbits; i++) begin
      serialClock <= 1'b0;
      serialDataIn <= word[31 - i];
      repeat (HALF) @(posedge sys_clk);
      if (i >= 16) begin
        rdata = {rdata[14:0], serialDataOut};
      end
      serialClock <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
    end
    chipSelect_n <= 1'b1;
    serialDataIn <= ~serialDataIn; // Released line keeps no last value
    repeat (40) @(posedge sys_clk); // Deselect gap
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// [testbench/spi_keypad_scanner_chk.sv]
// Port assertions of the serial keypad scanner
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Checker
module spi_keypad_scanner_chk #(
  parameter int unsigned DEBOUNCE_UNIT = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial host port
  input wire logic chipSelect_n,
  input wire logic serialClock,
  input wire logic serialDataOut,
  input wire logic serialDataOutOe_n,
  input wire logic busy,
  input wire logic busyOe_n,
  // Keypad matrix
  input wire logic [5:0] columnDriveLines,
  input wire logic [5:0] columnDriveOe_n,
  input wire logic keyIrq_n
);
  // Longest interrupt low time: debounce plus six settled columns
  localparam int LOW_LIMIT = 9 * DEBOUNCE_UNIT + 24100;
  logic [31:0] lowCount; // Cycles the interrupt has stayed low

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Count interrupt low time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCount <= 32'h0000_0000;
    end else if (keyIrq_n) begin
      lowCount <= 32'h0000_0000;
    end else begin
      lowCount <= lowCount + 32'h0000_0001;
    end
  end

  // Steps of a finished scan
  sequence s_scan_done;
    $rose(keyIrq_n);
  endsequence
  sequence s_held_off;
    keyIrq_n [*8];
  endsequence

  a_dout_float_idle: assert property (
    chipSelect_n [*6] |-> serialDataOutOe_n && busyOe_n)
    else $error("Output enabled while deselected");
  a_busy_held_low: assert property (
    !busy)
    else $error("Busy output asserted");
  a_dout_quiet_idle: assert property (
    chipSelect_n [*6] |-> !serialDataOut)
    else $error("Data output not low while deselected");
  a_dout_on_fall: assert property (
    $changed(serialDataOut) && !chipSelect_n |-> !serialClock)
    else $error("Data output changed while link clock high");
  a_col_one_hot: assert property (
    columnDriveOe_n != 6'h00 |-> $countones(~columnDriveOe_n) <= 1)
    else $error("Several columns driven during scan");
  a_col_drive_high: assert property (
    columnDriveOe_n == 6'h00 |-> columnDriveLines == 6'h3F)
    else $error("Armed columns not all high");
  a_col_settle_hold: assert property (
    $changed(columnDriveOe_n) && $countones(~columnDriveOe_n) == 1
    |=> $stable(columnDriveOe_n) [*8])
    else $error("Scanned column not held for settling");
  a_irq_armed_cols: assert property (
    $fell(keyIrq_n) |-> $past(columnDriveOe_n) == 6'h00)
    else $error("Interrupt raised while not armed");
  a_irq_low_bound: assert property (
    lowCount < LOW_LIMIT)
    else $error("Interrupt low past debounce and scan");
  a_irq_hold_off: assert property (
    s_scan_done |=> s_held_off)
    else $error("Interrupt returned right after scan");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n ##1 !rst_n |-> keyIrq_n && serialDataOutOe_n
    && columnDriveOe_n == 6'h3F)
    else $error("Outputs not quiet in reset");
endmodule : spi_keypad_scanner_chk

bind spi_keypad_scanner spi_keypad_scanner_chk #(
  .DEBOUNCE_UNIT(DEBOUNCE_UNIT)
) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .chipSelect_n(chipSelect_n),
  .serialClock(serialClock), .serialDataOut(serialDataOut),
  .serialDataOutOe_n(serialDataOutOe_n), .busyOe_n(busyOe_n),
  .busy(busy),
  .columnDriveLines(columnDriveLines), .columnDriveOe_n(columnDriveOe_n),
  .keyIrq_n(keyIrq_n)
);
`default_nettype wire

// [testbench/spi_keypad_scanner_tb_top.sv]
// Self-checking bench of the serial keypad scanner
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Bench top
module spi_keypad_scanner_tb_top;
  import keypad_scan_pkg::*;
  // One register case: address, value written, value read back
  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } row_type;
  localparam int DU = 20; // Short debounce unit
  localparam int LIMIT = 90000; // Cycle ceiling of the run
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chipSelect_n, serialClock, serialDataIn, serialDataOut;
  logic serialDataOutOe_n, keyIrq_n;
  logic [5:0] columnDriveLines, columnDriveOe_n;
  logic [4:0] rowSenseLines = 5'h00; // Rows rest low on pull-downs
  logic [29:0] keys = 30'h0000_0000; // Pressed keys, column*5+row
  logic [15:0] rd; // Last read word
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic [5:0] p0 [4] = '{6'h00, 6'h01, 6'h02, GPIO_PIN_LEVEL_OFS};
  row_type rows [12] = '{
    '{KEYPAD_CONFIG_OFS, 16'hFFFF, KEYPAD_CONFIG_WMASK},
    '{KEY_MASK_LOW_OFS, 16'hFFFF, KEY_MASK_WMASK},
    '{KEY_MASK_HIGH_OFS, 16'hFFFF, KEY_MASK_WMASK},
    '{COLUMN_MASK_OFS, 16'hFFFF, COLUMN_MASK_WMASK},
    '{POWER_DOWN_CONTROL_OFS, 16'hFFFF, POWER_DOWN_WMASK},
    '{GPIO_FUNCTION_SELECT_OFS, 16'hFFFF, GPIO_LOW_WMASK},
    '{GPIO_DIRECTION_OFS, 16'hFFFF, GPIO_HIGH_WMASK},
    '{GPIO_PULL_ENABLE_OFS, 16'hFFFF, GPIO_HIGH_WMASK},
    '{GPIO_OUTPUT_SETTING_OFS, 16'hFFFF, GPIO_HIGH_WMASK},
    '{PWM_CONTROL_OFS, 16'hFFFF, PWM_CONTROL_WMASK},
    '{6'h05, 16'hFFFF, REG_RESET},
    '{6'h3F, 16'hFFFF, REG_RESET}};

  // Clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Design and host
  spi_keypad_scanner #(.DEBOUNCE_UNIT(DU)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .chipSelect_n(chipSelect_n),
    .serialClock(serialClock), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut), .serialDataOutOe_n(serialDataOutOe_n),
    .busy(), .busyOe_n(), .columnDriveLines(columnDriveLines),
    .columnDriveOe_n(columnDriveOe_n), .rowSenseLines(rowSenseLines),
    .keyIrq_n(keyIrq_n));
  spi_host_model host (
    .sys_clk(sys_clk), .chipSelect_n(chipSelect_n),
    .serialClock(serialClock), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut));

  // Rows lifted by pressed keys on driven high columns
  function automatic logic [4:0] rowLevel(input logic [5:0] hot,
                                          input logic [29:0] k);
    logic [4:0] r;
    r = 5'h00;
    for (int c = 0; c < 6; c++) begin
      if (hot[c]) r = r | k[c * 5 +: 5];
    end
    return r;
  endfunction : rowLevel

  // Keypad matrix model
  always_ff @(posedge sys_clk) begin
    rowSenseLines <= rowLevel(columnDriveLines & ~columnDriveOe_n, keys);
  end

  // Comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Register read, page given
  task automatic rdReg(input logic page, input logic [5:0] a,
                       output logic [15:0] d);
    host.frame({8'h00, 1'b1, page, a}, 16'h0000, 32, d);
  endtask : rdReg

  // Control register write
  task automatic wrReg(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] junk;
    host.frame({8'h00, 1'b0, 1'b1, a}, d, 32, junk);
  endtask : wrReg

  // Bounded wait for an interrupt level
  task automatic waitIrq(input logic lvl, input int n);
    int i;
    i = 0;
    while (keyIrq_n !== lvl && i < n) begin
      @(posedge sys_clk);
      i++;
    end
    check({15'h0000, keyIrq_n}, {15'h0000, lvl});
  endtask : waitIrq

  // Verdict
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    foreach (rows[i]) begin
      rdReg(1'b1, rows[i].addr, rd);
      check(rd, REG_RESET);
      wrReg(rows[i].addr, rows[i].wdata);
      rdReg(1'b1, rows[i].addr, rd);
      check(rd, rows[i].rdata);
    end
    host.frame(16'h0000, 16'hFFFF, 32, rd); // Data page write is ignored
    foreach (p0[i]) begin
      rdReg(1'b0, p0[i], rd);
      check(rd, 16'h0000);
    end
    host.frame(16'h8000, 16'h0000, 32, rd);
    check(rd, 16'h0000);
    $display("done: register table");
    wrReg(KEYPAD_CONFIG_OFS, 16'h0800); // Two debounce units
    wrReg(KEY_MASK_LOW_OFS, 16'h0000);
    host.frame({8'h00, 2'b01, KEY_MASK_LOW_OFS}, 16'h1234, 20, rd);
    rdReg(1'b1, KEY_MASK_LOW_OFS, rd);
    check(rd, 16'h0000);
    wrReg(KEY_MASK_HIGH_OFS, 16'h0008); // Exclude column 3 row 3
    wrReg(COLUMN_MASK_OFS, 16'h0036); // Keep columns 0 and 3 only
    wrReg(POWER_DOWN_CONTROL_OFS, 16'h0000);
    repeat (4) @(posedge sys_clk);
    check({10'h000, columnDriveOe_n}, 16'h0000);
    check({10'h000, columnDriveLines}, 16'h003F);
    keys <= 30'h0005_0025;
    waitIrq(1'b0, 20);
    waitIrq(1'b1, 30000);
    repeat (400) @(posedge sys_clk);
    check({15'h0000, keyIrq_n}, 16'h0001);
    keys <= 30'h0000_0000;
    repeat (8) @(posedge sys_clk);
    rdReg(1'b0, KEYPAD_DATA_LOW_OFS, rd);
    check(rd, 16'h0005);
    rdReg(1'b0, KEYPAD_DATA_HIGH_OFS, rd);
    check(rd, 16'h0002);
    $display("done: key scan");
    wrReg(COLUMN_MASK_OFS, 16'h003E); // Scan column 0 only
    wrReg(SCAN_TRIGGER_OFS, 16'h1234);
    keys <= 30'h0000_0001; // Pressed only after the scan began
    repeat (5000) @(posedge sys_clk);
    keys <= 30'h0000_0000;
    rdReg(1'b0, KEYPAD_DATA_LOW_OFS, rd);
    check(rd, 16'h0001);
    $display("done: scan trigger");
    keys <= 30'h0000_0001; // Released before the debounce ends
    waitIrq(1'b0, 20);
    keys <= 30'h0000_0000;
    waitIrq(1'b1, 6000);
    rdReg(1'b0, KEYPAD_DATA_LOW_OFS, rd);
    check(rd, 16'h8000);
    $display("done: debounce error");
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rdReg(1'b1, COLUMN_MASK_OFS, rd);
    check(rd, REG_RESET);
    rdReg(1'b0, KEYPAD_DATA_LOW_OFS, rd);
    check(rd, REG_RESET);
    $display("done: reset");
    finish_test();
  end
endmodule : spi_keypad_scanner_tb_top
`default_nettype wire
